// ---- core/swp_act_host.sv ----
// frontend-side activation controller for the single-wire link
// What the document requires
// R1: data contact low while supply off
// R2: rising master voltage signal requests activation
// R3: deactivate data contact before removing supply
// R4: card resumes link once contact active
// R5: no resume means unsupported, deactivate contact
// R6: after resume, put link activated
// R7: card drops current signal within detection_timeout
// R8: card ignores link after detection failure
// R9: card sends first sync, then waits
// R10: good sync, full power: mode frame repeat 0
// R11: good sync, low power: success, stop
// R12: bad or missing sync: mode frame repeat 1
// R13: card repeats on 1, ready on 0
// R14: card ignores corrupted activation frames
// R15: success on sync-after-repeat or ready
// R16: corrupted answer: repeat-request mode frame again
// R17: missing answer: repeat, at most three
// R18: out-of-order frame counts as corrupted
// R19: failed activation: unsupported, deactivate contact
// R20: card sync frames carry activation info
// R21: other interface resets leave link alone
// R22: link actions never touch other interfaces
// R23: skip activation if known unsupported
// R24: detection_timeout at most 100 ms
// R25: card resumes within 700 us
// R26: card answers mode frame within 2000 us
// R27: reactivation: good first sync is success
// R28: card reports outcome and power mode
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "swp_act_regs.svh"
module swp_act_host #(
  parameter int unsigned RES_V_CYC = `SWP_T_RES_V_US * `SWP_CLK_MHZ,
  parameter int unsigned RES_D_CYC = `SWP_T_RES_D_US * `SWP_CLK_MHZ,
  parameter int unsigned ANS_CYC = `SWP_T_FRP_US * `SWP_CLK_MHZ,
  parameter int unsigned TW = 16
) (
  // clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic en_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // contacts
  output logic supply_contact_o,
  output logic master_voltage_signal_o,
  input wire logic slave_current_signal_i,
  // link state
  output logic link_activated_o,
  // frame layer
  output logic tx_req_o,
  output swp_act_pkg::act_frame_e tx_type_o,
  output logic tx_repeat_request_bit_o,
  output logic tx_low_power_o,
  input wire logic tx_done_i,
  input wire logic rx_valid_i,
  input wire swp_act_pkg::act_frame_e rx_type_i,
  input wire logic rx_ok_i,
  // outcome
  output swp_act_pkg::act_out_e outcome_o
);
  import swp_act_pkg::*;

  localparam logic [TW-1:0] RESV_LIM = TW'(RES_V_CYC - 1);
  localparam logic [TW-1:0] RESD_LIM = TW'(RES_D_CYC - 1);
  localparam logic [TW-1:0] ANS_LIM = TW'(ANS_CYC - 1);
  localparam logic [1:0] MAX_REP = 2'(`SWP_MAX_REP);

  // ==========================================================
  // slave current synchroniser
  logic [2:0] s2_q;
  logic [2:0] s2_d;
  logic s2_lvl_q;
  logic s2_lvl_d;

  always_comb begin
    s2_d = {s2_q[1:0], slave_current_signal_i};
    s2_lvl_d = s2_lvl_q;
    if (s2_q[1] == s2_q[2]) begin
      s2_lvl_d = s2_q[2];
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s2_q <= 3'h0;
      s2_lvl_q <= 1'b0;
    end else if (en_i) begin
      s2_q <= s2_d;
      s2_lvl_q <= s2_lvl_d;
    end
  end

  // ==========================================================
  // apb registers
  logic [31:0] prdata_d;
  logic pready_d;
  logic pslverr_d;
  logic sup_q;
  logic sup_d;
  logic lowpwr_q;
  logic lowpwr_d;
  logic react_q;
  logic react_d;
  logic wr;
  logic wr_ctrl;
  logic start;
  logic unsup_q;
  logic unsup_d;
  act_state_e st_q;
  act_state_e st_d;
  logic [1:0] rep_q;
  logic [1:0] rep_d;
  act_out_e out_q;
  act_out_e out_d;

  always_comb begin
    wr = psel_i & penable_i & pwrite_i & pready_o;
    wr_ctrl = wr & (paddr_i == `SWP_CTRL_OFS);
    start = wr_ctrl & pwdata_i[`SWP_CTRL_START];
    sup_d = sup_q;
    lowpwr_d = lowpwr_q;
    react_d = react_q;
    if (wr_ctrl) begin
      sup_d = pwdata_i[`SWP_CTRL_SUPPLY];
      lowpwr_d = pwdata_i[`SWP_CTRL_LOWPWR];
      react_d = pwdata_i[`SWP_CTRL_REACT];
    end
    pready_d = psel_i & ~penable_i;
    pslverr_d = 1'b0;
    prdata_d = prdata_o;
    if (psel_i & ~penable_i) begin
      prdata_d = 32'h0000_0000;
      if (paddr_i == `SWP_CTRL_OFS) begin
        prdata_d[`SWP_CTRL_SUPPLY] = sup_q;
        prdata_d[`SWP_CTRL_LOWPWR] = lowpwr_q;
        prdata_d[`SWP_CTRL_REACT] = react_q;
      end else if (paddr_i == `SWP_STAT_OFS) begin
        prdata_d[8:0] = st_q;
        prdata_d[`SWP_STAT_REP_LSB +: 2] = rep_q;
        prdata_d[`SWP_STAT_OUT_LSB +: 2] = out_q;
        prdata_d[`SWP_STAT_UNS] = unsup_q;
      end else begin
        pslverr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      sup_q <= 1'(`SWP_CTRL_RST >> `SWP_CTRL_SUPPLY);
      lowpwr_q <= 1'b0;
      react_q <= 1'b0;
    end else if (en_i) begin
      prdata_o <= prdata_d;
      pready_o <= pready_d;
      pslverr_o <= pslverr_d;
      sup_q <= sup_d;
      lowpwr_q <= lowpwr_d;
      react_q <= react_d;
    end
  end

  // ==========================================================
  // activation sequencer
  logic [TW-1:0] tmr_q;
  logic [TW-1:0] tmr_d;
  logic s1_d;
  logic supc_d;
  logic act_d;
  logic txr_d;
  act_frame_e txt_d;
  logic fr_d;
  logic lp_d;
  logic first_q;
  logic first_d;
  logic rx_bad;
  logic tmo;

  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q + TW'(1);
    s1_d = master_voltage_signal_o;
    act_d = link_activated_o;
    txr_d = tx_req_o;
    txt_d = tx_type_o;
    fr_d = tx_repeat_request_bit_o;
    lp_d = tx_low_power_o;
    rep_d = rep_q;
    first_d = first_q;
    out_d = out_q;
    unsup_d = unsup_q;
    rx_bad = rx_valid_i & ~rx_ok_i;
    tmo = 1'b0;
    if (wr_ctrl && pwdata_i[`SWP_CTRL_CLRUNS]) begin
      unsup_d = 1'b0;
    end
    // outside reset the data contact falls first, supply one cycle later
    supc_d = sup_q | (supply_contact_o & master_voltage_signal_o); // R3
    case (st_q)
      ST_IDLE: begin
        if (start && supply_contact_o && sup_q) begin
          tmr_d = '0;
          rep_d = 2'h0;
          first_d = 1'b0;
          out_d = OUT_BUSY;
          if (unsup_q) begin
            st_d = ST_SKIP; // R23
          end else begin
            s1_d = 1'b1; // R2
            st_d = ST_WRES;
          end
        end
      end
      ST_WRES: begin
        tmo = (tmr_q == (react_q ? RESD_LIM : RESV_LIM)); // R25
        if (s2_lvl_q) begin
          act_d = 1'b1; // R6
          tmr_d = '0;
          st_d = ST_WSYN; // R9
        end else if (tmo) begin
          st_d = ST_FAIL; // R5
        end
      end
      ST_WSYN: begin
        tmo = (tmr_q == ANS_LIM);
        if (rx_valid_i && rx_ok_i && rx_type_i == FR_SYNC) begin
          first_d = 1'b1;
          if (lowpwr_q || react_q) begin
            st_d = ST_DONE; // R11 R27
          end else begin
            fr_d = 1'b0; // R10
            st_d = ST_SEND;
          end
        end else if (rx_valid_i || tmo) begin
          fr_d = 1'b1; // R12 R18
          st_d = ST_SEND;
        end
        if (st_d == ST_SEND) begin
          txr_d = 1'b1;
          txt_d = FR_PMODE;
          lp_d = lowpwr_q;
          if (fr_d) begin
            rep_d = rep_q + 2'h1;
          end
        end
      end
      ST_SEND: begin
        tmr_d = '0;
        if (tx_done_i) begin
          txr_d = 1'b0;
          st_d = ST_WANS;
        end
      end
      ST_WANS: begin
        tmo = (tmr_q == ANS_LIM); // R26
        if (rx_valid_i && rx_ok_i && ((rx_type_i == FR_SYNC &&
            tx_repeat_request_bit_o) || (rx_type_i == FR_READY &&
            first_q))) begin
          st_d = ST_DONE; // R13 R15
        end else if (rx_valid_i || tmo) begin
          if (rep_q == MAX_REP) begin
            st_d = ST_FAIL; // R17
          end else begin
            rep_d = rep_q + 2'h1; // R16 R18
            fr_d = 1'b1;
            txr_d = 1'b1;
            lp_d = lowpwr_q;
            st_d = ST_SEND;
          end
        end
        if (rx_bad) begin
          tmo = 1'b0;
        end
      end
      ST_DONE: begin
        out_d = OUT_OK;
        if (start) begin
          st_d = ST_IDLE;
        end
      end
      ST_FAIL: begin
        s1_d = 1'b0; // R19
        act_d = 1'b0;
        txr_d = 1'b0;
        unsup_d = 1'b1;
        out_d = OUT_FAIL;
        st_d = ST_IDLE;
      end
      ST_SKIP: begin
        out_d = OUT_FAIL;
        st_d = ST_IDLE;
      end
      ST_DEAC: begin
        s1_d = 1'b0; // R3
        act_d = 1'b0;
        txr_d = 1'b0;
        out_d = OUT_IDLE;
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_DEAC;
      end
    endcase
    // shutdown request overrides the sequence, no other contact moves
    if (!sup_q && master_voltage_signal_o) begin
      s1_d = 1'b0; // R1 R22
      act_d = 1'b0;
      txr_d = 1'b0;
      st_d = ST_IDLE;
      out_d = OUT_IDLE;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= ST_IDLE;
      tmr_q <= '0;
      rep_q <= 2'h0;
      first_q <= 1'b0;
      unsup_q <= 1'b0;
      out_q <= OUT_IDLE;
      supply_contact_o <= 1'b0;
      master_voltage_signal_o <= 1'b0;
      link_activated_o <= 1'b0;
      tx_req_o <= 1'b0;
      tx_type_o <= FR_NONE;
      tx_repeat_request_bit_o <= 1'b0;
      tx_low_power_o <= 1'b0;
    end else if (en_i) begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      rep_q <= rep_d;
      first_q <= first_d;
      unsup_q <= unsup_d;
      out_q <= out_d;
      supply_contact_o <= supc_d;
      master_voltage_signal_o <= s1_d;
      link_activated_o <= act_d;
      tx_req_o <= txr_d;
      tx_type_o <= txt_d;
      tx_repeat_request_bit_o <= fr_d;
      tx_low_power_o <= lp_d;
    end
  end

  assign outcome_o = out_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  AST_S1_NO_SUPPLY: assert property ( // R1
    !supply_contact_o |-> !master_voltage_signal_o)
    else $error("data contact high without supply");
  AST_SUPPLY_ORDER: assert property ( // R3
    $fell(supply_contact_o) |-> !$past(master_voltage_signal_o))
    else $error("supply removed before data contact");
  AST_NO_RESUME: assert property ( // R5
    en_i && st_q == ST_WRES && !s2_lvl_q && tmo && sup_q
    |=> st_q == ST_FAIL ##1 !master_voltage_signal_o && unsup_q)
    else $error("missing resume did not deactivate");
  AST_RESUME_ACT: assert property ( // R6
    en_i && st_q == ST_WRES && s2_lvl_q && sup_q
    |=> link_activated_o && st_q == ST_WSYN)
    else $error("resume did not activate link");
  AST_FULL_FR0: assert property ( // R10
    en_i && sup_q && st_q == ST_WSYN && rx_valid_i && rx_ok_i &&
    rx_type_i == FR_SYNC && !lowpwr_q && !react_q
    |=> tx_req_o && !tx_repeat_request_bit_o && tx_type_o == FR_PMODE)
    else $error("full power answer not repeat 0");
  AST_LOW_DONE: assert property ( // R11
    en_i && sup_q && st_q == ST_WSYN && rx_valid_i && rx_ok_i &&
    rx_type_i == FR_SYNC && lowpwr_q |=> st_q == ST_DONE ##1 !tx_req_o)
    else $error("low power sync not final");
  AST_BAD_SYNC_FR1: assert property ( // R12
    en_i && sup_q && st_q == ST_WSYN && rx_bad
    |=> tx_req_o && tx_repeat_request_bit_o)
    else $error("bad sync not answered with repeat 1");
  AST_REP_MAX: assert property ( // R17
    en_i && sup_q && st_q == ST_WANS && rep_q == MAX_REP && tmo &&
    !rx_valid_i |=> st_q == ST_FAIL && !tx_req_o)
    else $error("too many repeat requests");
  AST_FAIL_DEACT: assert property ( // R19
    en_i && sup_q && st_q == ST_FAIL |=> !master_voltage_signal_o &&
    !link_activated_o && outcome_o == OUT_FAIL)
    else $error("failed activation left contact active");
  AST_SKIP: assert property ( // R23
    en_i && st_q == ST_IDLE && start && unsup_q && sup_q
    |=> !master_voltage_signal_o ##1 st_q == ST_IDLE)
    else $error("known unsupported card was activated");

  COV_FULL_OK: cover property (
    st_q == ST_WANS && tx_type_o == FR_PMODE ##1 st_q == ST_DONE);
  COV_LOW_OK: cover property (st_q == ST_WSYN ##1 st_q == ST_DONE);
  COV_FAIL_REP: cover property (st_q == ST_WANS && rep_q == MAX_REP
    ##1 st_q == ST_FAIL);
  COV_NO_RES: cover property (st_q == ST_WRES ##1 st_q == ST_FAIL);
endmodule

// ---- core/swp_act_regs.svh ----
// register offsets, fields and timing counts of the activation controller
`ifndef SWP_ACT_REGS_SVH
`define SWP_ACT_REGS_SVH
// ==========================================================
// register map
`define SWP_CTRL_OFS 12'h000
`define SWP_STAT_OFS 12'h004
`define SWP_CTRL_START 0
`define SWP_CTRL_SUPPLY 1
`define SWP_CTRL_LOWPWR 2
`define SWP_CTRL_REACT 3
`define SWP_CTRL_CLRUNS 4
`define SWP_CTRL_RST 32'h0000_0000
`define SWP_STAT_REP_LSB 9
`define SWP_STAT_OUT_LSB 11
`define SWP_STAT_UNS 13
// ==========================================================
// timing
`define SWP_CLK_MHZ 20
`define SWP_T_RES_V_US 700
`define SWP_T_RES_D_US 500
`define SWP_T_FRP_US 2000
`define SWP_MAX_REP 3
`endif

// ---- core/swp_act_pkg.sv ----
// types of the activation controller
package swp_act_pkg;
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_WRES = 9'h002,
    ST_WSYN = 9'h004,
    ST_SEND = 9'h008,
    ST_WANS = 9'h010,
    ST_DONE = 9'h020,
    ST_FAIL = 9'h040,
    ST_SKIP = 9'h080,
    ST_DEAC = 9'h100
  } act_state_e;
  typedef enum logic [1:0] {
    FR_NONE = 2'h0,
    FR_SYNC = 2'h1,
    FR_PMODE = 2'h2,
    FR_READY = 2'h3
  } act_frame_e;
  typedef enum logic [1:0] {
    OUT_IDLE = 2'h0,
    OUT_BUSY = 2'h1,
    OUT_OK = 2'h2,
    OUT_FAIL = 2'h3
  } act_out_e;
endpackage

// ---- sim/swp_card_model.sv ----
// card-side model of the single-wire link for activation tests
`timescale 1ns/10ps
module swp_card_model (
  // clock, contacts and link state
  input wire logic ref_clk_i,
  input wire logic volt_i,
  input wire logic link_i,
  output logic cur_o,
  // frame layer
  input wire logic req_i,
  input wire swp_act_pkg::act_frame_e type_i,
  input wire logic rep_i,
  output logic done_o,
  output logic rxv_o,
  output swp_act_pkg::act_frame_e rxt_o,
  output logic rxok_o,
  // faults ordered by the bench
  input wire logic no_res_i,
  input wire logic [1:0] bad_i,
  input wire logic mute_i
);
  import swp_act_pkg::*;
  logic dead = 1'h0;
  logic lk;
  logic fr;
  int nbad = 0;
  int n;
  act_frame_e last = FR_SYNC;
  // ==========================================================
  // frame out
  task automatic send(input act_frame_e t);
    rxv_o <= 1'h1;
    rxt_o <= t;
    rxok_o <= (nbad >= int'(bad_i));
    nbad++;
    last = t;
    @(posedge ref_clk_i);
    rxv_o <= 1'h0;
  endtask
  // ==========================================================
  // resume and detection timeout
  initial begin
    cur_o = 1'h0;
    forever begin
      @(posedge ref_clk_i);
      if (volt_i !== 1'h1) begin
        cur_o <= 1'h0;
        dead = 1'h0;
        nbad = 0;
      end else if (cur_o === 1'h0 && !dead) begin
        repeat (10) @(posedge ref_clk_i);
        cur_o <= volt_i & ~no_res_i;
        n = 0;
        while (link_i !== 1'h1 && n < 100) begin
          @(posedge ref_clk_i);
          n++;
        end
        if (link_i !== 1'h1) begin
          cur_o <= 1'h0;
          dead = 1'h1;
        end
      end
    end
  end
  // ==========================================================
  // activation frames
  initial begin
    done_o = 1'h0;
    rxv_o = 1'h0;
    rxt_o = FR_NONE;
    rxok_o = 1'h0;
    lk = 1'h0;
    forever begin
      @(posedge ref_clk_i);
      if (link_i === 1'h1 && !lk && !dead) begin
        repeat (5) @(posedge ref_clk_i);
        send(FR_SYNC);
      end
      if (req_i === 1'h1 && type_i === FR_PMODE && !dead) begin
        fr = rep_i;
        repeat (3) @(posedge ref_clk_i);
        done_o <= 1'h1;
        @(posedge ref_clk_i);
        done_o <= 1'h0;
        if (!mute_i) begin
          repeat (8) @(posedge ref_clk_i);
          send(fr ? last : FR_READY);
        end
      end
      lk = link_i;
    end
  end
endmodule

// ---- sim/tb_swp_act_host.sv ----
// testbench of the activation controller against a card model
`timescale 1ns/10ps
`include "swp_act_regs.svh"
module tb_swp_act_host;
  import swp_act_pkg::*;
  localparam logic [31:0] GO = 32'h1 << `SWP_CTRL_START;
  localparam logic [31:0] SUP = 32'h1 << `SWP_CTRL_SUPPLY;
  localparam logic [31:0] CLR = 32'h1 << `SWP_CTRL_CLRUNS;
  localparam logic [31:0] QM [2] = '{32'h1 << `SWP_CTRL_LOWPWR,
    32'h1 << `SWP_CTRL_REACT};
  logic ref_clk_i, reset_n_i, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic sup, volt, cur, link, req, trep, done, rxv, rxok, no_res;
  logic mute, err, lastfr, lp, lastlp;
  logic [1:0] corrupt;
  act_frame_e ttype, rxt;
  act_out_e outc;
  int bad_count = 0;
  int checks = 0;
  int npm = 0;
  swp_act_host #(.RES_V_CYC(40), .RES_D_CYC(30), .ANS_CYC(60)) i_dut (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .en_i(1'h1),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .supply_contact_o(sup),
    .master_voltage_signal_o(volt), .slave_current_signal_i(cur),
    .link_activated_o(link), .tx_req_o(req), .tx_type_o(ttype),
    .tx_repeat_request_bit_o(trep), .tx_low_power_o(lp),
    .tx_done_i(done), .rx_valid_i(rxv), .rx_type_i(rxt),
    .rx_ok_i(rxok), .outcome_o(outc));
  swp_card_model i_card (
    .ref_clk_i(ref_clk_i), .volt_i(volt), .link_i(link), .cur_o(cur),
    .req_i(req), .type_i(ttype), .rep_i(trep), .done_o(done),
    .rxv_o(rxv), .rxt_o(rxt), .rxok_o(rxok), .no_res_i(no_res),
    .bad_i(corrupt), .mute_i(mute));
  initial begin
    ref_clk_i = 1'h0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    if (req === 1'h1 && done === 1'h1 && ttype === FR_PMODE) begin
      npm++;
      lastfr = trep;
      lastlp = lp;
    end
  end
  // ==========================================================
  // tasks
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (pready !== 1'h1) begin
      bad_count++;
      stop_test();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  task automatic run(input logic [31:0] mode, input act_out_e o);
    int n;
    n = 0;
    npm = 0;
    reset_n_i <= 1'h0;
    repeat (20) @(posedge ref_clk_i);
    reset_n_i <= 1'h1;
    if (mode != 32'h0) begin
      apb(1'h1, `SWP_CTRL_OFS, mode);
      apb(1'h1, `SWP_CTRL_OFS, mode | GO);
      do begin
        apb(1'h0, `SWP_STAT_OFS, 32'h0);
        n++;
      end while (rd[`SWP_STAT_OUT_LSB +: 2] !== o && n < 300);
      chk("outcome", 32'(rd[`SWP_STAT_OUT_LSB +: 2]), 32'(o));
      chk("outcome pin", 32'(outc), 32'(o));
    end
  endtask
  // ==========================================================
  // tests
  initial begin
    {reset_n_i, psel, penable, pwrite, no_res, mute} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    corrupt = 2'h0;
    @(posedge ref_clk_i);
    run(32'h0, OUT_IDLE);
    chk("contacts", 32'({sup, volt}), 32'h0);
    apb(1'h1, 12'h00C, 32'hFFFF_FFFF);
    chk("unmapped", 32'(err), 32'h1);
    apb(1'h0, `SWP_CTRL_OFS, 32'h0);
    chk("ctrl", rd, `SWP_CTRL_RST);
    apb(1'h0, `SWP_STAT_OFS, 32'h0);
    chk("stat", rd, 32'h1);
    $display("test reset done");
    run(SUP, OUT_OK);
    chk("pm frames", 32'(npm), 32'h1);
    chk("fr bit", 32'(lastfr), 32'h0);
    chk("lp bit", 32'(lastlp), 32'h0);
    chk("contacts", 32'({link, volt, sup}), 32'h7);
    apb(1'h1, `SWP_CTRL_OFS, 32'h0);
    repeat (4) begin
      @(posedge ref_clk_i);
      if (volt === 1'h1 && sup !== 1'h1) chk("order", 32'h0, 32'h1);
    end
    chk("off", 32'({link, volt, sup}), 32'h0);
    $display("test full power done");
    foreach (QM[i]) begin
      run(SUP | QM[i], OUT_OK);
      chk("pm frames", 32'(npm), 32'h0);
    end
    $display("test low power and reactivation done");
    corrupt <= 2'h2;
    run(SUP | QM[0], OUT_OK);
    chk("repeats", 32'(rd[`SWP_STAT_REP_LSB +: 2]), 32'h2);
    chk("pm frames", 32'(npm), 32'h2);
    chk("fr bit", 32'(lastfr), 32'h1);
    chk("lp bit", 32'(lastlp), 32'h1);
    $display("test corrupted frames done");
    corrupt <= 2'h0;
    mute <= 1'h1;
    run(SUP, OUT_FAIL);
    chk("pm frames", 32'(npm), 32'h4);
    chk("unsup", 32'(rd[`SWP_STAT_UNS]), 32'h1);
    chk("contacts", 32'({sup, link, volt}), 32'h4);
    apb(1'h1, `SWP_CTRL_OFS, SUP | GO);
    apb(1'h0, `SWP_STAT_OFS, 32'h0);
    chk("skip", 32'({volt, rd[`SWP_STAT_OUT_LSB +: 2]}), 32'h3);
    apb(1'h1, `SWP_CTRL_OFS, SUP | CLR);
    apb(1'h0, `SWP_STAT_OFS, 32'h0);
    chk("unsup clear", 32'(rd[`SWP_STAT_UNS]), 32'h0);
    $display("test silent card done");
    mute <= 1'h0;
    no_res <= 1'h1;
    run(SUP, OUT_FAIL);
    chk("no resume", 32'({link, volt}), 32'h0);
    chk("pm frames", 32'(npm), 32'h0);
    $display("test no resume done");
    stop_test();
  end
endmodule
